// >>> shared/shr_defs.svh
// Constants for the star hub repeater: timing, register map, field layout.
`ifndef SHR_DEFS_SVH
`define SHR_DEFS_SVH

`define SHR_PORTS        12
`define SHR_UPLINK_CH    11
`define SHR_CLK_NS       25
`define SHR_JAB_WARN_MS  27
`define SHR_JAB_KILL_MS  54
`define SHR_JAB_WARN_CYC ((`SHR_JAB_WARN_MS * 1000000) / `SHR_CLK_NS)
`define SHR_JAB_KILL_CYC ((`SHR_JAB_KILL_MS * 1000000) / `SHR_CLK_NS)
`define SHR_JAB_W        22
`define SHR_TEST_STEP    22'h000400
`define SHR_SQ_NS        100
`define SHR_SQ_CYC       ((`SHR_SQ_NS + `SHR_CLK_NS - 1) / `SHR_CLK_NS)
`define SHR_STRETCH_NS   1000
`define SHR_STRETCH_CYC  ((`SHR_STRETCH_NS + `SHR_CLK_NS - 1) / `SHR_CLK_NS)
`define SHR_HALF_BIT_NS  500
`define SHR_HALF_BIT_CYC (`SHR_HALF_BIT_NS / `SHR_CLK_NS)
`define SHR_RT_DLY       8
`define SHR_PRE_CYC      160
`define SHR_MIN_FRAME    2560
`define SHR_CP_HALF      20
`define SHR_FR_W         12

`define SHR_REG_CTRL     8'h00
`define SHR_REG_ACT      8'h04
`define SHR_REG_JAB      8'h08
`define SHR_REG_STATE    8'h0C
`define SHR_CTRL_RST     12'hFFF

`endif

// >>> shared/shr_pkg.sv
// Types shared by the star hub repeater.
package shr_pkg;

	typedef struct packed {
		logic min_frame;
		logic pre_regen;
		logic crs_high;
		logic retime;
		logic int_squelch;
		logic ih_role;
		logic normal;
	} shr_mode_t;

	typedef enum logic [1:0] {
		SHR_UP_IDLE,
		SHR_UP_FWD,
		SHR_UP_COLL
	} shr_up_state_t;

endpackage : shr_pkg

// >>> src/shr_hub.sv
// Twelve-port star hub: collision detector, repeater, jabber guard and status.
// Contract
// - Upstream path has up to twelve inputs, one output; downstream one input, twelve outputs.
// - Intermediate role reserves channel 11 for downlink; header role uses it as port.
// - Hub-level pin high selects intermediate role, low selects header role.
// - Operation pin high is normal operation, low is test mode.
// - Squelch pin high applies internal squelch; low expects external pulse stretching.
// - Retimer pin high enables serial retiming; low bypasses it.
// - Bypassed retiming adds only gate-level delay, no bit-period delay; the bypass here adds one 25 ns register stage.
// - Polarity pin high means carriers active high; low means active low.
// - Preamble pin high regenerates lost early preamble; low disables it.
// - Frame-length pin high enforces minimum forwarded frame length; low does not.
// - Activity on more than one upstream input at once is a collision.
// - After collision, send collision presence while any upstream input is active.
// - Single active input is retimed, cleaned of jitter and forwarded upstream.
// - A port transmitting longer than 27 ms triggers collision presence.
// - A port transmitting until 54 ms total is disabled and marked jabbed.
// - A jabbed port is re-enabled only after it returns to idle.
// - Downstream retimes upper-hub signal and replicates it onto every port output.
// - Per-port status outputs show line activity and jabber state.
// - Reversed wire-pair polarity on a port is compensated automatically.
// - Repeater logic handles serial rates up to 2 Mb/s besides the standard rate.
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "shr_defs.svh"

module shr_hub #(
	parameter int unsigned JAB_WARN_CYC  = `SHR_JAB_WARN_CYC,
	parameter int unsigned JAB_KILL_CYC  = `SHR_JAB_KILL_CYC,
	parameter int unsigned MIN_FRAME_CYC = `SHR_MIN_FRAME,
	parameter int unsigned CP_HALF_CYC   = `SHR_CP_HALF
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire shr_pkg::shr_mode_t mode,
	input  wire logic [11:0]       port_crs,
	input  wire logic [11:0]       port_rxd,
	output logic      [11:0]       port_txe_q,
	output logic      [11:0]       port_txd_q,
	output logic                   up_txe_q,
	output logic                   up_txd_q,
	output logic      [11:0]       stat_act_q,
	output logic      [11:0]       stat_jab_q,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [31:0]       wb_dat_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic              wb_we_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o
);

	logic [11:0]               car;
	logic [11:0]               dat;
	logic [11:0]               act;
	logic [11:0]               warn;
	logic [11:0]               jab_q;
	logic [11:0]               inv_q;
	logic [11:0]               car_prev_q;
	logic [11:0]               ctrl_en_q;
	logic [`SHR_JAB_W-1:0]     jcnt_q [12];
	logic [3:0]                n_act;
	logic [3:0]                sel_idx;
	logic                      any_act;
	shr_pkg::shr_up_state_t    up_state_q;
	shr_pkg::shr_up_state_t    up_state_d;
	logic                      cp_q;
	logic                      cp_wave_q;
	logic [5:0]                cp_cnt_q;
	logic                      pat_q;
	logic [5:0]                pat_cnt_q;
	logic [2:0]                maj_q;
	logic                      clean;
	logic [`SHR_RT_DLY-1:0]    up_dly_q;
	logic [`SHR_RT_DLY-1:0]    dn_dly_q;
	logic [`SHR_FR_W-1:0]      fr_cnt_q;
	logic                      in_fr_q;
	logic                      up_txe_d;
	logic                      up_txd_d;
	logic                      dn_src_e;
	logic                      dn_src_d;
	logic                      dn_e_q;
	logic                      wb_req;

	// Per-port front end: polarity, squelch, wiring reversal, jabber
	for (genvar i = 0; i < 12; i++) begin : g_port
		logic       raw;
		logic [2:0] sq_q;
		logic [5:0] str_q;
		logic       sq_on;

		assign raw = port_crs[i] ~^ mode.crs_high;
		assign sq_on = (sq_q == 3'(`SHR_SQ_CYC)) || (str_q != 6'h00);

		// Glitches shorter than the qualify time never count as carrier while internal squelch is selected
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				sq_q  <= 3'h0;
				str_q <= 6'h00;
			end else begin
				if (!raw)
					sq_q <= 3'h0;
				else if (sq_q != 3'(`SHR_SQ_CYC))
					sq_q <= sq_q + 3'h1;
				if (raw && sq_q == 3'(`SHR_SQ_CYC))
					str_q <= 6'(`SHR_STRETCH_CYC);
				else if (str_q != 6'h00)
					str_q <= str_q - 6'h01;
			end
		end

		assign car[i] = mode.int_squelch ? sq_on : raw;
		assign dat[i] = port_rxd[i] ^ inv_q[i];
		assign warn[i] = jcnt_q[i] > `SHR_JAB_W'(JAB_WARN_CYC);

		// Idle line rests high, so a low first sample means a swapped pair
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				car_prev_q[i] <= 1'b0;
				inv_q[i]      <= 1'b0;
			end else begin
				car_prev_q[i] <= car[i];
				if (car[i] && !car_prev_q[i])
					inv_q[i] <= ~port_rxd[i];
			end
		end

		// Test mode speeds the jabber timer up for production checks
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				jcnt_q[i] <= '0;
			end else if (!car[i]) begin
				jcnt_q[i] <= '0;
			end else if (jcnt_q[i] < `SHR_JAB_W'(JAB_KILL_CYC)) begin
				jcnt_q[i] <= mode.normal ? jcnt_q[i] + `SHR_JAB_W'(1) : jcnt_q[i] + `SHR_TEST_STEP;
			end
		end

		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b)
				jab_q[i] <= 1'b0;
			else if (car[i] && jcnt_q[i] >= `SHR_JAB_W'(JAB_KILL_CYC))
				jab_q[i] <= 1'b1;
			else if (!car[i])
				jab_q[i] <= 1'b0;
		end

		assign act[i] = car[i] && ctrl_en_q[i] && !jab_q[i] && !(mode.ih_role && i == `SHR_UPLINK_CH);

		chk_jab_release: assert property (@(posedge clk) disable iff (!rst_b)
			jab_q[i] && !car[i] |=> !jab_q[i])
			else $error("jabbed port not released at idle");
		chk_jab_needs_time: assert property (@(posedge clk) disable iff (!rst_b)
			$rose(jab_q[i]) |-> $past(jcnt_q[i]) >= `SHR_JAB_W'(JAB_KILL_CYC))
			else $error("port jabbed before kill time");
	end

	function automatic logic [3:0] count_ones(input logic [11:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int k = 0; k < 12; k++)
			n = n + {3'h0, v[k]};
		return n;
	endfunction

	always_comb begin
		sel_idx = 4'h0;
		for (int k = 11; k >= 0; k--)
			if (act[k])
				sel_idx = 4'(k);
	end

	assign n_act   = count_ones(act);
	assign any_act = n_act != 4'h0;

	// Upstream arbitration
	always_comb begin
		up_state_d = up_state_q;
		case (up_state_q)
			shr_pkg::SHR_UP_IDLE: begin
				if (n_act > 4'h1)
					up_state_d = shr_pkg::SHR_UP_COLL;
				else if (n_act == 4'h1)
					up_state_d = shr_pkg::SHR_UP_FWD;
			end
			shr_pkg::SHR_UP_FWD: begin
				if (n_act > 4'h1)
					up_state_d = shr_pkg::SHR_UP_COLL;
				else if (!any_act)
					up_state_d = shr_pkg::SHR_UP_IDLE;
			end
			shr_pkg::SHR_UP_COLL: begin
				if (!any_act)
					up_state_d = shr_pkg::SHR_UP_IDLE;
			end
			default: up_state_d = shr_pkg::SHR_UP_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			up_state_q <= shr_pkg::SHR_UP_IDLE;
		else
			up_state_q <= up_state_d;
	end

	// Collision presence waveform; period is a parameter
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cp_q      <= 1'b0;
			cp_wave_q <= 1'b0;
			cp_cnt_q  <= 6'h00;
		end else begin
			cp_q <= (up_state_d == shr_pkg::SHR_UP_COLL) || ((warn & act) != 12'h000);
			if (cp_cnt_q == 6'(CP_HALF_CYC - 1)) begin
				cp_cnt_q  <= 6'h00;
				cp_wave_q <= ~cp_wave_q;
			end else begin
				cp_cnt_q <= cp_cnt_q + 6'h01;
			end
		end
	end

	// Preamble pattern at the standard bit rate
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pat_q     <= 1'b1;
			pat_cnt_q <= 6'h00;
		end else if (!in_fr_q) begin
			pat_q     <= 1'b1;
			pat_cnt_q <= 6'h00;
		end else if (pat_cnt_q == 6'(`SHR_HALF_BIT_CYC - 1)) begin
			pat_q     <= ~pat_q;
			pat_cnt_q <= 6'h00;
		end else begin
			pat_cnt_q <= pat_cnt_q + 6'h01;
		end
	end

	// Majority of three samples rejects single-sample jitter spikes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			maj_q <= 3'h7;
		else
			maj_q <= {maj_q[1:0], dat[sel_idx]};
	end

	assign clean = (maj_q[0] & maj_q[1]) | (maj_q[1] & maj_q[2]) | (maj_q[0] & maj_q[2]);

	// Serial retiming line; eight samples still sit well inside a 2 Mb/s bit
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			up_dly_q <= '1;
			dn_dly_q <= '1;
		end else begin
			up_dly_q <= {up_dly_q[`SHR_RT_DLY-2:0], clean};
			dn_dly_q <= {dn_dly_q[`SHR_RT_DLY-2:0], dn_src_d};
		end
	end

	// Frame tracking for minimum length and preamble fill
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			in_fr_q  <= 1'b0;
			fr_cnt_q <= '0;
		end else if (any_act && !in_fr_q) begin
			in_fr_q  <= 1'b1;
			fr_cnt_q <= '0;
		end else if (in_fr_q) begin
			if (fr_cnt_q != '1)
				fr_cnt_q <= fr_cnt_q + `SHR_FR_W'(1);
			if (!any_act && !(mode.min_frame && fr_cnt_q < `SHR_FR_W'(MIN_FRAME_CYC - 1)))
				in_fr_q <= 1'b0;
		end
	end

	always_comb begin
		up_txe_d = any_act || in_fr_q;
		if (cp_q)
			up_txd_d = cp_wave_q;
		else if (mode.pre_regen && in_fr_q && fr_cnt_q < `SHR_FR_W'(`SHR_PRE_CYC))
			up_txd_d = pat_q;
		else if (!any_act)
			up_txd_d = 1'b1;
		else if (mode.retime)
			up_txd_d = up_dly_q[`SHR_RT_DLY-1];
		else
			up_txd_d = dat[sel_idx];
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			up_txe_q <= 1'b0;
			up_txd_q <= 1'b1;
		end else begin
			up_txe_q <= up_txe_d;
			up_txd_q <= up_txd_d;
		end
	end

	// Downstream source: uplink port in intermediate role, own output in header role
	assign dn_src_e = mode.ih_role ? car[`SHR_UPLINK_CH] : up_txe_d;
	assign dn_src_d = mode.ih_role ? dat[`SHR_UPLINK_CH] : up_txd_d;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dn_e_q     <= 1'b0;
			port_txe_q <= 12'h000;
			port_txd_q <= 12'hFFF;
		end else begin
			dn_e_q     <= dn_src_e;
			port_txe_q <= {12{dn_src_e}};
			port_txd_q <= {12{mode.retime ? dn_dly_q[`SHR_RT_DLY-1] : dn_src_d}};
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_act_q <= 12'h000;
			stat_jab_q <= 12'h000;
		end else begin
			stat_act_q <= car;
			stat_jab_q <= jab_q;
		end
	end

	// Wishbone slave: ack one cycle after the strobe, unmapped reads give zero
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_en_q <= `SHR_CTRL_RST;
		end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == `SHR_REG_CTRL) begin
			if (wb_sel_i[0])
				ctrl_en_q[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				ctrl_en_q[11:8] <= wb_dat_i[11:8];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_req && !wb_we_i) begin
			case (wb_adr_i)
				`SHR_REG_CTRL:  wb_dat_o <= {20'h00000, ctrl_en_q};
				`SHR_REG_ACT:   wb_dat_o <= {20'h00000, car};
				`SHR_REG_JAB:   wb_dat_o <= {20'h00000, jab_q};
				`SHR_REG_STATE: wb_dat_o <= {21'h000000, mode, dn_e_q, cp_q, up_txe_q, up_state_q == shr_pkg::SHR_UP_COLL};
				default:        wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	chk_coll_detect: assert property (@(posedge clk) disable iff (!rst_b)
		n_act > 4'h1 |=> up_state_q == shr_pkg::SHR_UP_COLL ##1 up_txd_q == $past(cp_wave_q))
		else $error("collision not signalled");
	chk_coll_hold: assert property (@(posedge clk) disable iff (!rst_b)
		up_state_q == shr_pkg::SHR_UP_COLL && any_act |=> up_state_q == shr_pkg::SHR_UP_COLL && cp_q)
		else $error("collision presence dropped while inputs active");
	chk_warn_cp: assert property (@(posedge clk) disable iff (!rst_b)
		(warn & act) != 12'h000 |=> cp_q)
		else $error("long transmission without collision presence");
	chk_ih_reserve: assert property (@(posedge clk) disable iff (!rst_b)
		mode.ih_role |-> !act[`SHR_UPLINK_CH])
		else $error("uplink channel joined upstream arbitration");
	chk_bypass_path: assert property (@(posedge clk) disable iff (!rst_b)
		!mode.retime && n_act == 4'h1 && !cp_q && !(mode.pre_regen && in_fr_q && fr_cnt_q < `SHR_FR_W'(`SHR_PRE_CYC))
		|=> up_txd_q == $past(dat[sel_idx]))
		else $error("bypass added delay");
	chk_dn_replicate: assert property (@(posedge clk) disable iff (!rst_b)
		port_txd_q == {12{port_txd_q[0]}} && port_txe_q == {12{$past(dn_src_e)}})
		else $error("downstream outputs differ");
	chk_min_frame: assert property (@(posedge clk) disable iff (!rst_b)
		mode.min_frame && in_fr_q && fr_cnt_q < `SHR_FR_W'(MIN_FRAME_CYC - 2) |=> in_fr_q && up_txe_q)
		else $error("frame shorter than minimum");
	chk_single_fwd: assert property (@(posedge clk) disable iff (!rst_b)
		n_act == 4'h1 |=> up_txe_q)
		else $error("single input not forwarded");
	chk_wb_ack: assert property (@(posedge clk) disable iff (!rst_b)
		wb_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not a single-cycle ack");

endmodule : shr_hub

`default_nettype wire

// >>> dv/shr_node_model.sv
// Behavioural stations on the hub's twelve port lines.
`timescale 1ns/10ps
`default_nettype none
module shr_node_model (
	input  wire logic        clk,
	input  wire logic        crs_high,
	input  wire logic        abort,
	output wire logic [11:0] port_crs,
	output logic      [11:0] port_rxd
);
	logic [11:0] act;

	assign port_crs = crs_high ? act : ~act;

	initial begin
		act = 12'h000;
		port_rxd = 12'hFFF;
	end

	// Data held per half bit of hb cycles; idle line rests high
	task automatic send(input logic [11:0] m, input int n, input logic inv, input int hb);
		int   i;
		logic d;
		d = ~inv;
		for (i = 0; i < n && !abort; i++) begin
			@(posedge clk);
			if (i % hb == 0 && i > 0)
				d = 1'($urandom);
			act <= m;
			port_rxd <= ~m | {12{d}};
		end
		@(posedge clk);
		act <= 12'h000;
		port_rxd <= 12'hFFF;
	endtask : send
endmodule : shr_node_model
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the star hub repeater.
`timescale 1ns/10ps
`default_nettype none
`include "shr_defs.svh"
module testbench;
	localparam int WARN = 300;
	localparam int KILL = 600;
	localparam int MINF = 200;
	logic               clk = 1'b0;
	logic               rst_b = 1'b0;
	shr_pkg::shr_mode_t mode = shr_pkg::shr_mode_t'(7'h11);
	logic               abort = 1'b0;
	wire logic [11:0]   port_crs;
	wire logic [11:0]   port_rxd;
	logic [11:0]        port_txe_q, port_txd_q, stat_act_q, stat_jab_q;
	logic               up_txe_q, up_txd_q, wb_ack_o;
	logic [31:0]        wb_dat_o, q, r;
	logic [7:0]         wb_adr_i = 8'h00;
	logic [31:0]        wb_dat_i = 32'h0;
	logic [3:0]         wb_sel_i = 4'h0;
	logic               wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, p;
	int                 err_total = 0, compares = 0, cyc = 0, k, s, d, t;
	logic [11:0]        rx_h [0:32767];
	logic               up_h [0:32767];
	logic               dn_h [0:32767];
	// Mode, port, cycles, carrier expected (-1 skip), jabbed expected
	int                 pt [7][5] = '{'{'h01, 3, 40, 1, 0}, '{'h15, 3, 2, 0, 0}, '{'h15, 3, 40, 1, 0},
		'{'h11, 3, 2, 1, 0}, '{'h13, 11, 40, 0, 0}, '{'h11, 11, 40, 1, 0}, '{'h10, 3, 40, -1, 1}};

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		rx_h[cyc] = port_rxd;
		up_h[cyc] = up_txd_q;
		dn_h[cyc] = port_txd_q[0];
		cyc = cyc + 1;
	end

	shr_hub #(.JAB_WARN_CYC(WARN), .JAB_KILL_CYC(KILL), .MIN_FRAME_CYC(MINF)) shr_hub_i (.clk(clk), .rst_b(rst_b),
		.mode(mode),
		.port_crs(port_crs), .port_rxd(port_rxd), .port_txe_q(port_txe_q), .port_txd_q(port_txd_q),
		.up_txe_q(up_txe_q), .up_txd_q(up_txd_q), .stat_act_q(stat_act_q), .stat_jab_q(stat_jab_q),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

	shr_node_model shr_node_model_i (.clk(clk), .crs_high(mode.crs_high), .abort(abort),
		.port_crs(port_crs), .port_rxd(port_rxd));

	function automatic logic exp_bit(input logic rx, input logic inv);
		return rx ^ inv;
	endfunction : exp_bit

	function automatic logic [31:0] state_exp(input logic [6:0] m, input logic [3:0] f);
		return {21'h0, m, f};
	endfunction : state_exp

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic done(input string m);
		$display("test %s finished", m);
	endtask : done

	task automatic restart(input logic [6:0] m);
		@(posedge clk);
		rst_b <= 1'b0;
		mode <= shr_pkg::shr_mode_t'(m);
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
	endtask : restart

	task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] dw, output logic [31:0] dr);
		int n;
		@(posedge clk);
		wb_adr_i <= a;
		wb_we_i <= we;
		wb_dat_i <= dw;
		wb_sel_i <= 4'hF;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		chk(32'(wb_ack_o), 1, "bus ack");
		dr = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task automatic probe(input int pk, input int n, input int etx, input int ejb);
		logic tx;
		logic jb;
		tx = 1'b0;
		jb = 1'b0;
		fork
			shr_node_model_i.send(12'(1 << pk), n, 1'b0, 20);
			repeat (n + 12) begin
				@(posedge clk);
				tx |= up_txe_q;
				jb |= stat_jab_q[pk];
			end
		join
		if (etx >= 0)
			chk(32'(tx), 32'(etx), "upstream carrier");
		chk(32'(jb), 32'(ejb), "jabbed flag");
	endtask : probe

	task automatic results();
		$display("comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		results();
	end

	initial begin
		void'($urandom(31534));
		restart(7'h11);
		#1;
		chk({6'h0, up_txe_q, up_txd_q, port_txe_q, port_txd_q}, 32'h01000FFF, "reset outputs");
		chk({8'h0, stat_act_q, stat_jab_q}, 32'h0, "reset status");
		wb(8'h00, 1'b0, 32'h0, q);
		chk(q, 32'h00000FFF, "mask reset");
		r = $urandom;
		wb(8'h00, 1'b1, r, q);
		wb(8'h00, 1'b0, 32'h0, q);
		chk(q, {20'h0, r[11:0]}, "mask rw");
		wb(8'h08, 1'b1, r, q);
		wb(8'h08, 1'b0, 32'h0, q);
		chk(q, 32'h0, "read-only");
		wb(8'h40, 1'b0, 32'h0, q);
		chk(q, 32'h0, "unmapped");
		wb(8'h0C, 1'b0, 32'h0, q);
		chk(q, state_exp(7'h11, 4'h0), "state pins");
		k = $urandom_range(10);
		wb(8'h00, 1'b1, ~(32'h1 << k), q);
		probe(k, 40, 0, 0);
		wb(8'h00, 1'b1, 32'hFFF, q);
		probe(k, 40, 1, 0);
		done("registers");
		foreach (pt[i]) begin
			restart(pt[i][0][6:0]);
			probe(pt[i][1], pt[i][2], pt[i][3], pt[i][4]);
		end
		done("modes");
		for (int m = 0; m < 8; m++) begin
			restart({3'b001, m[1], 3'b001});
			k = $urandom_range(10);
			s = cyc;
			fork
				shr_node_model_i.send(12'(1 << k), 160, m[0], m[2] ? 10 : 20);
				begin
					repeat (100) @(posedge clk);
					chk({20'h0, port_txe_q}, 32'hFFF, "downstream carrier");
					chk(32'(port_txd_q == 12'h000 || port_txd_q == 12'hFFF), 1, "replicas");
				end
			join
			d = m[1] ? 12 : 1;
			for (int c = s + 30; c < s + 130; c++)
				if (rx_h[c - 3][k] === rx_h[c + 3][k]) begin
					chk(32'(up_h[c + d]), 32'(exp_bit(rx_h[c][k], m[0])), "data");
					chk(32'(dn_h[c + d + (m[1] ? 8 : 0)]), 32'(exp_bit(rx_h[c][k], m[0])), "dn data");
				end
		end
		done("data path");
		restart(7'h11);
		fork
			shr_node_model_i.send(12'h0C0, 400, 1'b0, 20);
			begin
				repeat (20) @(posedge clk);
				wb(8'h0C, 1'b0, 32'h0, q);
				chk(q, state_exp(7'h11, 4'hF), "collision");
				t = 0;
				p = up_txd_q;
				repeat (80) begin
					@(posedge clk);
					t += (up_txd_q !== p);
					p = up_txd_q;
				end
				chk(32'(t >= 3), 1, "presence wave");
				abort <= 1'b1;
			end
		join
		t = 0;
		while (up_txe_q !== 1'b0 && t < 10) begin
			@(posedge clk);
			t++;
		end
		chk(32'(up_txe_q), 0, "presence end");
		abort <= 1'b0;
		done("collision");
		restart(7'h11);
		k = $urandom_range(10);
		fork
			shr_node_model_i.send(12'(1 << k), 700, 1'b0, 20);
			begin
				repeat (60) @(posedge clk);
				wb(8'h04, 1'b0, 32'h0, q);
				chk(q, 32'(1 << k), "activity");
				chk({20'h0, stat_act_q}, 32'(1 << k), "activity pins");
				repeat (300) @(posedge clk);
				wb(8'h0C, 1'b0, 32'h0, q);
				chk(32'(q[2]), 1, "jabber warning");
				repeat (300) @(posedge clk);
				wb(8'h08, 1'b0, 32'h0, q);
				chk(q, 32'(1 << k), "jabbed");
				chk(32'(up_txe_q), 0, "port dropped");
			end
		join
		repeat (4) @(posedge clk);
		chk({20'h0, stat_jab_q}, 32'h0, "released");
		probe(k, 40, 1, 0);
		done("jabber");
		restart(7'h51);
		k = $urandom_range(10);
		t = 0;
		fork
			shr_node_model_i.send(12'(1 << k), 40, 1'b0, 20);
			repeat (MINF + 60) begin
				@(posedge clk);
				t += up_txe_q;
			end
		join
		chk(32'(t >= MINF && t <= MINF + 2), 1, "minimum frame");
		restart(7'h31);
		k = $urandom_range(10);
		fork
			shr_node_model_i.send(12'(1 << k), 200, 1'b1, 20);
			begin
				t = 0;
				while (up_txe_q !== 1'b1 && t < 20) begin
					@(posedge clk);
					t++;
				end
				for (int j = 1; j < 150; j++) begin
					@(posedge clk);
					chk(32'(up_txd_q), 32'(((j - 1) / `SHR_HALF_BIT_CYC) % 2 == 0), "preamble fill");
				end
			end
		join
		done("frame options");
		results();
	end
endmodule : testbench
`default_nettype wire
